// ---- include/hpm_pkg.sv ----
package hpm_pkg;

  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_SPHDR    = 8'h08;
  localparam logic [7:0]  OFF_LSVAL    = 8'h0c;
  localparam logic [7:0]  OFF_LEVAL    = 8'h10;
  localparam logic [7:0]  OFF_FSVAL    = 8'h14;
  localparam logic [7:0]  OFF_FEVAL    = 8'h18;
  localparam logic [7:0]  OFF_LPHDR    = 8'h1c;
  localparam logic [7:0]  OFF_LPPYLD   = 8'h20;
  localparam logic [7:0]  OFF_CHIRPS   = 8'h24;
  localparam logic [7:0]  OFF_LL_BASE  = 8'h80;

  localparam int          CTRL_SEL_BIT   = 0;
  localparam int          CTRL_SWRST_BIT = 1;
  localparam int          CTRL_LAST_LSB  = 8;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0002;
  localparam logic [31:0] CFG_RESET      = 32'h0000_0000;

  localparam int          LL_SIZE_LSB  = 0;
  localparam int          LL_SIZE_W    = 16;
  localparam int          LL_HS_BIT    = 16;
  localparam int          LL_HE_BIT    = 17;
  localparam int          LL_LPH_BIT   = 18;
  localparam int          LL_VALID_BIT = 31;

  localparam int          ST_IDX_LSB   = 8;
  localparam int          ST_CHIRP_LSB = 16;

  localparam logic [31:0] LVDS_CRC_ON  = 32'h5555_5555;
  localparam logic [31:0] LVDS_CRC_OFF = 32'haaaa_aaaa;

  localparam int          SYNC_STAGES  = 3;
  localparam int          FIFO_DEPTH   = 4;
  localparam int          LL_DEPTH     = 32;
  localparam int          CHIRP_W      = 16;

  typedef enum logic [2:0] {
    HPM_IDLE   = 3'b000,
    HPM_FSTART = 3'b001,
    HPM_WCHIRP = 3'b011,
    HPM_LSTART = 3'b010,
    HPM_LHDR   = 3'b110,
    HPM_DATA   = 3'b111,
    HPM_LEND   = 3'b101,
    HPM_FEND   = 3'b100
  } hpm_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } hpm_bus_t;

  typedef struct packed {
    logic        wr;
    logic [31:0] addr;
    logic [31:0] data;
  } hpm_pe_req_t;

  typedef struct packed {
    logic        valid;
    logic        crcEn;
    logic [31:0] data;
  } hpm_lane_t;

endpackage : hpm_pkg

// ---- rtl/hpm_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module hpm_fifo #(
  parameter int W = 32,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic [W-1:0]      outData,
  input  wire logic         outReady
);
  localparam int PW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0]   count_q;
  logic [PW:0]   countNext;
  logic          ready_q;
  logic          push;
  logic          pop;

  // registered not-full keeps the top-level ready straight from a flop
  assign inReady   = ready_q;
  assign countNext = count_q + (PW+1)'(push) - (PW+1)'(pop);
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
      ready_q <= 1'b1;
    end else begin
      if (push) wrPtr_q <= (wrPtr_q == PW'(D-1)) ? '0 : wrPtr_q + 1'b1;
      if (pop) rdPtr_q <= (rdPtr_q == PW'(D-1)) ? '0 : rdPtr_q + 1'b1;
      count_q <= countNext;
      ready_q <= (countNext != (PW+1)'(D));
    end
  end
endmodule : hpm_fifo
`default_nettype wire

// ---- rtl/hpm_trig_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module hpm_trig_sync
  import hpm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      risePulse_q
);
  logic [SYNC_STAGES-1:0] sync_q;
  logic                   level_q;

  // change counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q      <= '0;
      level_q     <= 1'b0;
      risePulse_q <= 1'b0;
    end else begin
      sync_q      <= {sync_q[SYNC_STAGES-2:0], pinIn};
      risePulse_q <= 1'b0;
      if (sync_q[1] == sync_q[2]) begin
        level_q     <= sync_q[2];
        risePulse_q <= sync_q[2] && !level_q;
      end
    end
  end
endmodule : hpm_trig_sync
`default_nettype wire

// ---- rtl/hpm_marker_ctrl.sv ----
// Behaviour
// - lvds mode: line start value 0x55555555 enables crc, 0xaaaaaaaa disables it.
// - walk the linked list once per chirp, for the programmed chirps per frame.
// - up to 32 linked-list entries drive actions and transitions.
// - lvds mode still steps sync states but emits nothing for them.
// - lvds lanes carry only data, never sync or long headers.
// - select bit 0 routes to csi, 1 routes to lvds.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module hpm_marker_ctrl
  import hpm_pkg::*;
#(
  parameter int DATA_W = 32,
  parameter int LL_N   = LL_DEPTH,
  parameter int FIFO_D = FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire hpm_bus_t          regBus,
  output logic [31:0]            rdData_q,
  input  wire logic              frameStartPin,
  input  wire logic              chirpAvailPin,
  input  wire logic              inValid,
  input  wire logic [DATA_W-1:0] inData,
  output logic                   inReady,
  output hpm_pe_req_t            peReq_q,
  output hpm_lane_t              lane_q
);
  localparam int IW = $clog2(LL_N);

  function automatic logic isLl(input logic [7:0] a);
    isLl = (a >= OFF_LL_BASE) && ({1'b0, a[7:2]} < 7'(OFF_LL_BASE[7:2] + LL_N));
  endfunction : isLl

  logic [31:0]       ctrl_q;
  logic [31:0]       spHdr_q;
  logic [31:0]       lsVal_q;
  logic [31:0]       leVal_q;
  logic [31:0]       fsVal_q;
  logic [31:0]       feVal_q;
  logic [31:0]       lpHdr_q;
  logic [31:0]       lpPyld_q;
  logic [31:0]       chirps_q;
  logic [31:0]       ll_q [LL_N];
  hpm_state_t        state_q;
  hpm_state_t        state_d;
  logic [IW-1:0]     idx_q;
  logic [CHIRP_W-1:0] chirp_q;
  logic [LL_SIZE_W-1:0] left_q;
  logic              frameTrig;
  logic              chirpTrig;
  logic              fifoValid;
  logic [DATA_W-1:0] fifoData;
  logic              pop;
  logic              lvdsSel;
  logic              swRst;
  logic [IW-1:0]     lastIdx;
  logic [31:0]       entry;
  logic              lastChirp;
  logic              crcOn;
  logic [31:0]       status;
  logic [LL_SIZE_W-1:0] entrySize;

  assign lvdsSel   = ctrl_q[CTRL_SEL_BIT];
  assign swRst     = ctrl_q[CTRL_SWRST_BIT];
  assign lastIdx   = ctrl_q[CTRL_LAST_LSB +: IW];
  assign entry     = ll_q[idx_q];
  assign entrySize = entry[LL_SIZE_LSB +: LL_SIZE_W];
  assign lastChirp = ({16'h0000, chirp_q + 16'h0001} >= chirps_q);
  assign crcOn     = (lsVal_q == LVDS_CRC_ON);
  assign pop       = (state_q == HPM_DATA) && fifoValid && (left_q != '0);
  assign status    = {chirp_q, 3'h0, 5'(idx_q), 3'h0, crcOn, lvdsSel, state_q};

  hpm_trig_sync u_frameSync (
    .clk         (clk),
    .rst_b       (rst_b),
    .pinIn       (frameStartPin),
    .risePulse_q (frameTrig)
  );

  hpm_trig_sync u_chirpSync (
    .clk         (clk),
    .rst_b       (rst_b),
    .pinIn       (chirpAvailPin),
    .risePulse_q (chirpTrig)
  );

  hpm_fifo #(.W(DATA_W), .D(FIFO_D)) u_fifo (
    .clk      (clk),
    .rst_b    (rst_b),
    .inValid  (inValid),
    .inData   (inData),
    .inReady  (inReady),
    .outValid (fifoValid),
    .outData  (fifoData),
    .outReady (pop)
  );

  // configuration writes; the soft-reset window is software's to respect
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q   <= CTRL_RESET;
      spHdr_q  <= CFG_RESET;
      lsVal_q  <= CFG_RESET;
      leVal_q  <= CFG_RESET;
      fsVal_q  <= CFG_RESET;
      feVal_q  <= CFG_RESET;
      lpHdr_q  <= CFG_RESET;
      lpPyld_q <= CFG_RESET;
      chirps_q <= CFG_RESET;
    end else if (regBus.wr) begin
      unique case (regBus.addr)
        OFF_CTRL:   ctrl_q   <= regBus.wdata;
        OFF_SPHDR:  spHdr_q  <= regBus.wdata;
        OFF_LSVAL:  lsVal_q  <= regBus.wdata;
        OFF_LEVAL:  leVal_q  <= regBus.wdata;
        OFF_FSVAL:  fsVal_q  <= regBus.wdata;
        OFF_FEVAL:  feVal_q  <= regBus.wdata;
        OFF_LPHDR:  lpHdr_q  <= regBus.wdata;
        OFF_LPPYLD: lpPyld_q <= regBus.wdata;
        OFF_CHIRPS: chirps_q <= regBus.wdata;
        default: ;
      endcase
    end
  end

  // linked-list entry storage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < LL_N; i++) begin
        ll_q[i] <= CFG_RESET;
      end
    end else if (regBus.wr && isLl(regBus.addr)) begin
      ll_q[regBus.addr[2 +: IW]] <= regBus.wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q <= 32'h0000_0000;
    end else if (regBus.rd) begin
      if (isLl(regBus.addr)) begin
        rdData_q <= ll_q[regBus.addr[2 +: IW]];
      end else begin
        unique case (regBus.addr)
          OFF_CTRL:   rdData_q <= ctrl_q;
          OFF_STATUS: rdData_q <= status;
          OFF_SPHDR:  rdData_q <= spHdr_q;
          OFF_LSVAL:  rdData_q <= lsVal_q;
          OFF_LEVAL:  rdData_q <= leVal_q;
          OFF_FSVAL:  rdData_q <= fsVal_q;
          OFF_FEVAL:  rdData_q <= feVal_q;
          OFF_LPHDR:  rdData_q <= lpHdr_q;
          OFF_LPPYLD: rdData_q <= lpPyld_q;
          OFF_CHIRPS: rdData_q <= chirps_q;
          default:    rdData_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // frame, chirp and entry sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      HPM_IDLE:   if (frameTrig) state_d = HPM_FSTART;
      HPM_FSTART: state_d = HPM_WCHIRP;
      HPM_WCHIRP: if (chirpTrig) state_d = HPM_LSTART;
      HPM_LSTART: state_d = entry[LL_VALID_BIT] ? HPM_LHDR : HPM_LEND;
      HPM_LHDR:   state_d = HPM_DATA;
      HPM_DATA:   if (left_q == '0) state_d = HPM_LEND;
      HPM_LEND: begin
        if (idx_q != lastIdx) state_d = HPM_LSTART;
        else if (lastChirp) state_d = HPM_FEND;
        else state_d = HPM_WCHIRP;
      end
      HPM_FEND:   state_d = HPM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= HPM_IDLE;
    end else if (swRst) begin
      state_q <= HPM_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q   <= '0;
      chirp_q <= '0;
    end else if (swRst || state_q == HPM_FSTART) begin
      idx_q   <= '0;
      chirp_q <= '0;
    end else if (state_q == HPM_LEND) begin
      if (idx_q != lastIdx) begin
        idx_q <= idx_q + 1'b1;
      end else begin
        idx_q   <= '0;
        chirp_q <= chirp_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= '0;
    end else if (swRst) begin
      left_q <= '0;
    end else if (state_q == HPM_LHDR) begin
      left_q <= entrySize;
    end else if (pop) begin
      left_q <= left_q - 1'b1;
    end
  end

  // protocol engine writes: short packets, long header, payload
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      peReq_q <= '0;
    end else begin
      peReq_q.wr <= 1'b0;
      if (!swRst && !lvdsSel) begin
        unique case (state_q)
          HPM_FSTART: peReq_q <= '{1'b1, spHdr_q, fsVal_q};
          HPM_LSTART: if (entry[LL_VALID_BIT] && entry[LL_HS_BIT]) begin
            peReq_q <= '{1'b1, spHdr_q, lsVal_q};
          end
          HPM_LHDR:   if (entry[LL_LPH_BIT]) begin
            peReq_q <= '{1'b1, lpHdr_q, {16'h0000, entry[LL_SIZE_LSB +: LL_SIZE_W]}};
          end
          HPM_DATA:   if (pop) begin
            peReq_q <= '{1'b1, lpPyld_q, 32'(fifoData)};
          end
          HPM_LEND:   if (entry[LL_VALID_BIT] && entry[LL_HE_BIT]) begin
            peReq_q <= '{1'b1, spHdr_q, leVal_q};
          end
          HPM_FEND:   peReq_q <= '{1'b1, spHdr_q, feVal_q};
          default: ;
        endcase
      end
    end
  end

  // lvds lanes see payload words only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lane_q <= '0;
    end else begin
      lane_q.valid <= 1'b0;
      lane_q.crcEn <= crcOn;
      if (lvdsSel && pop && !swRst) begin
        lane_q.valid <= 1'b1;
        lane_q.data  <= 32'(fifoData);
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence frameOpen_s;
    state_q == HPM_IDLE && !swRst ##1 state_q == HPM_FSTART && !swRst && !lvdsSel;
  endsequence

  sequence lastEntry_s;
    state_q == HPM_LEND && !swRst && idx_q == lastIdx;
  endsequence

  frame_start_write_a: assert property (frameOpen_s |=> peReq_q.wr && peReq_q.addr == $past(spHdr_q)
    && peReq_q.data == $past(fsVal_q))
    else $error("frame start short packet missing");

  lvds_no_engine_a: assert property (peReq_q.wr |-> !$past(lvdsSel))
    else $error("engine write while lvds selected");

  lane_route_a: assert property (lane_q.valid |-> $past(lvdsSel) && $past(state_q) == HPM_DATA)
    else $error("lane word outside lvds data phase");

  crc_select_a: assert property (##1 lane_q.crcEn == ($past(lsVal_q) == LVDS_CRC_ON))
    else $error("crc enable not taken from line start value");

  frame_done_a: assert property (lastEntry_s and lastChirp |=> state_q == HPM_FEND)
    else $error("frame did not end after last chirp");

  chirp_loop_a: assert property (lastEntry_s and !lastChirp |=> state_q == HPM_WCHIRP
    && chirp_q == $past(chirp_q) + 1'b1 && idx_q == '0)
    else $error("chirp loop did not restart list");

  entry_step_a: assert property (state_q == HPM_LEND && !swRst && idx_q != lastIdx
    |=> state_q == HPM_LSTART && idx_q == $past(idx_q) + 1'b1)
    else $error("linked list did not advance");

  line_end_write_a: assert property (state_q == HPM_LEND && !swRst && !lvdsSel
    && entry[LL_VALID_BIT] && entry[LL_HE_BIT] |=> peReq_q.wr && peReq_q.data == $past(leVal_q))
    else $error("line end short packet missing");

  csi_route_a: assert property (pop && !lvdsSel && !swRst |=> peReq_q.wr
    && peReq_q.addr == $past(lpPyld_q) && !lane_q.valid)
    else $error("csi payload not sent to engine");

  sequence lineOpen_s;
    state_q == HPM_LSTART && !swRst && !lvdsSel && entry[LL_VALID_BIT] && entry[LL_HS_BIT];
  endsequence

  line_start_write_a: assert property (lineOpen_s |=> peReq_q.wr && peReq_q.addr == $past(spHdr_q)
    && peReq_q.data == $past(lsVal_q))
    else $error("line start short packet missing");

  frame_end_write_a: assert property (state_q == HPM_FEND && !swRst && !lvdsSel |=> peReq_q.wr
    && peReq_q.addr == $past(spHdr_q) && peReq_q.data == $past(feVal_q))
    else $error("frame end short packet missing");

  header_write_a: assert property (state_q == HPM_LHDR && !swRst && !lvdsSel && entry[LL_LPH_BIT]
    |=> peReq_q.wr && peReq_q.addr == $past(lpHdr_q) && peReq_q.data == {16'h0000, $past(entrySize)})
    else $error("long header write missing");

  entry_size_a: assert property (state_q == HPM_LHDR && !swRst |=> state_q == HPM_DATA
    && left_q == $past(entrySize))
    else $error("entry size not loaded");

  invalid_skip_a: assert property (state_q == HPM_LSTART && !swRst && !entry[LL_VALID_BIT]
    |=> state_q == HPM_LEND)
    else $error("invalid entry not skipped");

  lane_data_a: assert property (pop && lvdsSel && !swRst |=> lane_q.valid && !peReq_q.wr
    && lane_q.data == $past(fifoData))
    else $error("lvds payload word missing");

  frame_trig_a: assert property (state_q == HPM_IDLE && frameTrig && !swRst |=> state_q == HPM_FSTART)
    else $error("frame trigger not taken");

  chirp_trig_a: assert property (state_q == HPM_WCHIRP && chirpTrig && !swRst |=> state_q == HPM_LSTART)
    else $error("chirp trigger not taken");

endmodule : hpm_marker_ctrl
`default_nettype wire

// ---- tb/hpm_pe_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hpm_pe_model
  import hpm_pkg::*;
(
  input wire logic        clk,
  input wire hpm_pe_req_t peReq,
  input wire hpm_lane_t   lane
);
  logic [31:0] peAddr[$];
  logic [31:0] peData[$];
  logic [32:0] laneWord[$];
  // engine and lanes take every word at once, no back-pressure
  always @(posedge clk) begin
    if (peReq.wr === 1'b1) begin
      peAddr.push_back(peReq.addr);
      peData.push_back(peReq.data);
    end
    if (lane.valid === 1'b1) begin
      laneWord.push_back({lane.crcEn, lane.data});
    end
  end
endmodule : hpm_pe_model
`default_nettype wire

// ---- tb/tb_hpm_marker_ctrl.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_hpm_marker_ctrl;
  import hpm_pkg::*;
  localparam logic [7:0] OFFS [7] = '{OFF_SPHDR, OFF_LSVAL, OFF_LEVAL, OFF_FSVAL, OFF_FEVAL, OFF_LPHDR, OFF_LPPYLD};
  logic        clk;
  logic        rst_b;
  hpm_bus_t    regBus;
  logic [31:0] rdData_q;
  logic        frameStartPin;
  logic        chirpAvailPin;
  logic        inValid;
  logic [31:0] inData;
  logic        inReady;
  hpm_pe_req_t peReq_q;
  hpm_lane_t   lane_q;
  int          fails;
  int          check_count;
  int          seed;
  int          n0;
  int          l0;
  logic [31:0] v;
  logic [31:0] cfg[7];
  logic [31:0] words[$];
  logic [31:0] expA[$];
  logic [31:0] expD[$];

  hpm_marker_ctrl DUT (.clk(clk), .rst_b(rst_b), .regBus(regBus), .rdData_q(rdData_q),
    .frameStartPin(frameStartPin), .chirpAvailPin(chirpAvailPin), .inValid(inValid),
    .inData(inData), .inReady(inReady), .peReq_q(peReq_q), .lane_q(lane_q));
  hpm_pe_model PE (.clk(clk), .peReq(peReq_q), .lane(lane_q));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [32:0] laneExp(input logic [31:0] ls, input logic [31:0] w);
    laneExp = {(ls == LVDS_CRC_ON), w};
  endfunction : laneExp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regBus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    regBus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    regBus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk);
    regBus.rd <= 1'b0;
    #1 d = rdData_q;
  endtask : rd

  // caller is just past an edge; valid stays up for the next push
  task automatic push(input logic [31:0] d);
    inValid <= 1'b1;
    inData  <= d;
    for (int k = 0; k < 50; k++) begin
      @(posedge clk);
      if (inReady === 1'b1) return;
    end
    fails++;
    results();
  endtask : push

  task automatic waitState(input logic [2:0] s);
    logic [31:0] st;
    for (int k = 0; k < 200; k++) begin
      rd(OFF_STATUS, st);
      if (st[2:0] === s) return;
    end
    fails++;
    results();
  endtask : waitState

  task automatic pulse(input bit chirp);
    @(posedge clk);
    if (chirp) chirpAvailPin <= 1'b1;
    else frameStartPin <= 1'b1;
    repeat (4) @(posedge clk);
    chirpAvailPin <= 1'b0;
    frameStartPin <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse

  task automatic runFrame(input int n);
    pulse(1'b0);
    for (int c = 0; c < n; c++) begin
      waitState(3'h3);
      pulse(1'b1);
    end
    waitState(3'h0);
  endtask : runFrame

  task automatic addExp(input logic [31:0] a, input logic [31:0] d);
    expA.push_back(a);
    expD.push_back(d);
  endtask : addExp

  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    results();
  end

  initial begin
    regBus = '0;
    frameStartPin = 1'b0;
    chirpAvailPin = 1'b0;
    inValid = 1'b0;
    inData = 32'h0;
    fails = 0;
    check_count = 0;
    seed = 21;
    rst_b = 1'b0;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    rd(OFF_CTRL, v);
    chk(v, CTRL_RESET);
    rd(8'h40, v);
    chk(v, 32'h0);
    $display("test reset done");
    // csi: two chirps, entry 0 full, entry 1 invalid
    for (int i = 0; i < 7; i++) cfg[i] = $random(seed);
    wr(OFF_CTRL, 32'h0000_0002);
    for (int i = 0; i < 7; i++) wr(OFFS[i], cfg[i]);
    wr(OFF_CHIRPS, 32'h0000_0002);
    wr(OFF_LL_BASE, 32'h8007_0002);
    wr(OFF_LL_BASE + 8'h04, 32'h0000_0000);
    wr(OFF_LL_BASE + 8'h08, 32'h8000_0000);
    rd(OFF_LL_BASE, v);
    chk(v, 32'h8007_0002);
    for (int i = 0; i < 7; i++) begin
      rd(OFFS[i], v);
      chk(v, cfg[i]);
    end
    for (int i = 0; i < 4; i++) begin
      words.push_back($random(seed));
      push(words[i]);
    end
    inData <= $random(seed);
    repeat (3) @(posedge clk);
    inValid <= 1'b0;
    #1 chk(inReady, 1'b0);
    wr(OFF_CTRL, 32'h0000_0200);
    runFrame(2);
    addExp(cfg[0], cfg[3]);
    for (int c = 0; c < 2; c++) begin
      addExp(cfg[0], cfg[1]);
      addExp(cfg[5], 32'h2);
      addExp(cfg[6], words[2*c]);
      addExp(cfg[6], words[2*c+1]);
      addExp(cfg[0], cfg[2]);
    end
    addExp(cfg[0], cfg[4]);
    chk(33'(PE.peAddr.size()), 33'(expA.size()));
    for (int i = 0; i < expA.size() && i < PE.peAddr.size(); i++) begin
      chk(PE.peAddr[i], expA[i]);
      chk(PE.peData[i], expD[i]);
    end
    $display("test csi frame done");
    for (int k = 0; k < 2; k++) begin
      wr(OFF_CTRL, 32'h0000_0003);
      wr(OFF_SPHDR, 32'h5555_5555);
      wr(OFF_LPHDR, 32'h5555_5555);
      v = (k == 0) ? LVDS_CRC_ON : LVDS_CRC_OFF;
      wr(OFF_LSVAL, v);
      wr(OFF_LEVAL, (k == 0) ? 32'h3333_3333 : 32'haaaa_aaaa);
      wr(OFF_FSVAL, 32'haaaa_aaaa);
      wr(OFF_FEVAL, 32'haaaa_aaaa);
      wr(OFF_CHIRPS, 32'h0000_0001);
      wr(OFF_CTRL, 32'h0000_0101);
      n0 = PE.peAddr.size();
      l0 = PE.laneWord.size();
      words.delete();
      for (int i = 0; i < 2; i++) begin
        words.push_back($random(seed));
        push(words[i]);
      end
      inValid <= 1'b0;
      runFrame(1);
      chk(33'(PE.peAddr.size()), 33'(n0));
      chk(33'(PE.laneWord.size()), 33'(l0 + 2));
      for (int i = 0; i < 2 && l0 + i < PE.laneWord.size(); i++) begin
        chk(PE.laneWord[l0+i], laneExp(v, words[i]));
      end
      rd(OFF_STATUS, v);
      chk(v, {16'h0001, 11'h000, (k == 0), 1'b1, 3'h0});
      $display("test lvds frame %0d done", k);
    end
    results();
  end
endmodule : tb_hpm_marker_ctrl
`default_nettype wire
